// *** rtl/gpio_port_consts.vh ***
`ifndef GPIO_PORT_CONSTS_VH
`define GPIO_PORT_CONSTS_VH

// =====================================================================
// register indices (word index; byte address is four times the index)
// =====================================================================
`define PORT_CTRL_IDX          18'h0_C006
`define PORT_LOW_OUT_IDX       18'h0_C01E
`define PORT_LOW_IN_IDX        18'h0_C020
`define PORT_LOW_DIR_IDX       18'h0_C022
`define PORT_HIGH_OUT_IDX      18'h0_C024
`define PORT_HIGH_IN_IDX       18'h0_C026
`define PORT_HIGH_DIR_IDX      18'h0_C028
`define IRQ_STATUS_IDX         18'h0_C02A
`define IRQ_MASK_IDX           18'h0_C02C

`define REG_ADDR(idx)          ({(idx), 2'b00})

// =====================================================================
// port control fields
// =====================================================================
`define CTRL_LINE0_EN_BIT      0
`define CTRL_LINE0_POL_BIT     1
`define CTRL_LINE1_EN_BIT      2
`define CTRL_LINE1_POL_BIT     3
`define CTRL_MODE_LSB          8
`define CTRL_MODE_MSB          10
`define CTRL_WPROT_BIT         15
`define CTRL_WRITABLE_MASK     16'hCFFF
`define CTRL_MODE_PROT_MASK    16'h0700
`define MODE_PLAIN_GPIO        3'h0

// =====================================================================
// pins and reset values
// =====================================================================
`define LINE0_PIN              24
`define LINE1_PIN              25
`define MODE_OWNED_PINS        32'h01F8_FFFF
`define HALF_RESET             16'h0000
`define CTRL_RESET             16'h0000
`define IRQ_RESET              2'h0

`endif

// *** rtl/gpio_port_with_edge_irqs.v ***
`timescale 1ns/100ps
`include "gpio_port_consts.vh"

module gpio_port_with_edge_irqs #(
  parameter ADDR_W  = 20,
  parameter PINS    = 32,
  parameter HALF_W  = 16
) (
  input  wire              clock_i,
  input  wire              reset_n_i,
  input  wire              ce_i,
  // apb slave
  input  wire              psel_i,
  input  wire              penable_i,
  input  wire              pwrite_i,
  input  wire [ADDR_W-1:0] paddr_i,
  input  wire [31:0]       pwdata_i,
  output reg  [31:0]       prdata_o,
  output wire              pready_o,
  output reg               pslverr_o,
  // pins
  input  wire [PINS-1:0]   gpio_in_i,
  output wire [PINS-1:0]   gpio_out_o,
  output wire [PINS-1:0]   gpio_oe_n_o,
  // toward the processor
  input  wire              proc_irq_enable_i,
  output wire              ext_interrupt_line_zero_o,
  output wire              ext_interrupt_line_one_o,
  output wire              irq_o
);

  // ===================================================================
  // bus decode
  // ===================================================================
  reg                ready_q;
  reg  [15:0]        port_ctrl;
  reg  [1:0]         irq_status;
  reg  [1:0]         irq_mask;
  reg  [15:0]        next_ctrl;
  reg  [31:0]        next_rdata;
  reg                next_err;

  wire [HALF_W-1:0]  low_out;
  wire [HALF_W-1:0]  low_dir;
  wire [HALF_W-1:0]  high_out;
  wire [HALF_W-1:0]  high_dir;
  wire [1:0]         line_edge;
  wire [1:0]         line_event;
  wire [1:0]         line_pol;
  wire [1:0]         line_pin;

  wire setup_phase = psel_i & ~penable_i;
  wire access_done = psel_i & penable_i & ready_q;
  wire wr_access   = access_done & pwrite_i;

  wire hit_ctrl     = (paddr_i == `REG_ADDR(`PORT_CTRL_IDX));
  wire hit_low_out  = (paddr_i == `REG_ADDR(`PORT_LOW_OUT_IDX));
  wire hit_low_in   = (paddr_i == `REG_ADDR(`PORT_LOW_IN_IDX));
  wire hit_low_dir  = (paddr_i == `REG_ADDR(`PORT_LOW_DIR_IDX));
  wire hit_high_out = (paddr_i == `REG_ADDR(`PORT_HIGH_OUT_IDX));
  wire hit_high_in  = (paddr_i == `REG_ADDR(`PORT_HIGH_IN_IDX));
  wire hit_high_dir = (paddr_i == `REG_ADDR(`PORT_HIGH_DIR_IDX));
  wire hit_status   = (paddr_i == `REG_ADDR(`IRQ_STATUS_IDX));
  wire hit_mask     = (paddr_i == `REG_ADDR(`IRQ_MASK_IDX));
  wire hit_any      = hit_ctrl | hit_low_out | hit_low_in | hit_low_dir | hit_high_out |
                      hit_high_in | hit_high_dir | hit_status | hit_mask;
  // input data registers are read only; a write there is flagged as an error
  wire hit_ro       = hit_low_in | hit_high_in;

  // no wait state; read data is registered in the setup phase so that it leaves a flip-flop
  assign pready_o = ready_q;

  always @(posedge clock_i)
  begin
    if (!reset_n_i)
      ready_q <= 1'b0;
    else if (ce_i)
      ready_q <= setup_phase;
  end

  // ===================================================================
  // read mux
  // ===================================================================
  always @*
  begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    if (!hit_any)
      next_err = 1'b1;
    else if (pwrite_i & hit_ro)
      next_err = 1'b1;
    if (hit_ctrl)
      next_rdata = {16'h0000, port_ctrl};
    if (hit_low_out)
      next_rdata = {16'h0000, low_out};
    if (hit_low_in)
      next_rdata = {16'h0000, gpio_in_i[HALF_W-1:0]};
    if (hit_low_dir)
      next_rdata = {16'h0000, low_dir};
    if (hit_high_out)
      next_rdata = {16'h0000, high_out};
    if (hit_high_in)
      next_rdata = {16'h0000, gpio_in_i[PINS-1:HALF_W]};
    if (hit_high_dir)
      next_rdata = {16'h0000, high_dir};
    if (hit_status)
      next_rdata = {30'h0000_0000, irq_status};
    if (hit_mask)
      next_rdata = {30'h0000_0000, irq_mask};
  end

  always @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (setup_phase)
      begin
        prdata_o  <= pwrite_i ? 32'h0000_0000 : next_rdata;
        pslverr_o <= next_err;
      end
      else if (access_done)
      begin
        prdata_o  <= 32'h0000_0000;
        pslverr_o <= 1'b0;
      end
    end
  end

  // ===================================================================
  // port control register
  // ===================================================================
  // bits 12 and 13 are not stored; unused bits 4-7, 11 and 14 are stored and read back but drive nothing
  always @*
  begin
    next_ctrl = port_ctrl;
    if (wr_access & hit_ctrl)
    begin
      next_ctrl = pwdata_i[15:0] & `CTRL_WRITABLE_MASK;
      // once protection is on the pin-use field keeps its value until reset
      // the protect bit itself is sticky too, else two writes could undo the lock
      if (port_ctrl[`CTRL_WPROT_BIT])
      begin
        next_ctrl = (next_ctrl & ~`CTRL_MODE_PROT_MASK) | (port_ctrl & `CTRL_MODE_PROT_MASK);
        next_ctrl[`CTRL_WPROT_BIT] = 1'b1;
      end
    end
  end

  always @(posedge clock_i)
  begin
    if (!reset_n_i)
      port_ctrl <= `CTRL_RESET;
    else if (ce_i)
      port_ctrl <= next_ctrl;
  end

  wire [2:0] pin_mode   = port_ctrl[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
  wire       plain_mode = (pin_mode == `MODE_PLAIN_GPIO);

  // ===================================================================
  // output data and direction halves
  // ===================================================================
  port_half_regs #(
    .WIDTH (HALF_W)
  ) u_low_half (
    .clock_i     (clock_i),
    .reset_n_i   (reset_n_i),
    .ce_i        (ce_i),
    .wr_data_i   (wr_access & hit_low_out),
    .wr_dir_i    (wr_access & hit_low_dir),
    .wdata_i     (pwdata_i[HALF_W-1:0]),
    .out_data_o  (low_out),
    .direction_o (low_dir)
  );

  port_half_regs #(
    .WIDTH (HALF_W)
  ) u_high_half (
    .clock_i     (clock_i),
    .reset_n_i   (reset_n_i),
    .ce_i        (ce_i),
    .wr_data_i   (wr_access & hit_high_out),
    .wr_dir_i    (wr_access & hit_high_dir),
    .wdata_i     (pwdata_i[HALF_W-1:0]),
    .out_data_o  (high_out),
    .direction_o (high_dir)
  );

  // ===================================================================
  // pin drivers
  // ===================================================================
  wire [PINS-1:0] all_dir   = {high_dir, low_dir};
  wire [PINS-1:0] mode_keep = plain_mode ? {PINS{1'b1}} : ~`MODE_OWNED_PINS;

  // other pin uses are not built here, so owned pins simply stop driving
  assign gpio_out_o  = {high_out, low_out};
  assign gpio_oe_n_o = ~(all_dir & mode_keep);

  // ===================================================================
  // external interrupt lines
  // ===================================================================
  assign line_pin[0] = gpio_in_i[`LINE0_PIN];
  assign line_pin[1] = gpio_in_i[`LINE1_PIN];
  assign line_pol[0] = port_ctrl[`CTRL_LINE0_POL_BIT];
  assign line_pol[1] = port_ctrl[`CTRL_LINE1_POL_BIT];

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_line
      line_edge_detect u_detect (
        .clock_i   (clock_i),
        .reset_n_i (reset_n_i),
        .ce_i      (ce_i),
        .pin_i     (line_pin[g]),
        .rising_i  (line_pol[g]),
        .edge_o    (line_edge[g])
      );
    end
  endgenerate

  assign line_event[0] = line_edge[0] & port_ctrl[`CTRL_LINE0_EN_BIT];
  assign line_event[1] = line_edge[1] & port_ctrl[`CTRL_LINE1_EN_BIT];

  assign ext_interrupt_line_zero_o = line_event[0] & proc_irq_enable_i;
  assign ext_interrupt_line_one_o  = line_event[1] & proc_irq_enable_i;

  // ===================================================================
  // sticky status and mask
  // ===================================================================
  // a new edge in the clearing cycle wins over the write-one-to-clear
  always @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      irq_status <= `IRQ_RESET;
      irq_mask   <= `IRQ_RESET;
    end
    else if (ce_i)
    begin
      if (wr_access & hit_status)
        irq_status <= (irq_status & ~pwdata_i[1:0]) | line_event;
      else
        irq_status <= irq_status | line_event;
      if (wr_access & hit_mask)
        irq_mask <= pwdata_i[1:0];
    end
  end

  assign irq_o = (|(irq_status & irq_mask)) & proc_irq_enable_i;

endmodule // gpio_port_with_edge_irqs

// *** rtl/line_edge_detect.v ***
`timescale 1ns/100ps

// =====================================================================
// two-stage synchroniser and selectable edge detector for one line
// =====================================================================
module line_edge_detect (
  input  wire clock_i,
  input  wire reset_n_i,
  input  wire ce_i,
  input  wire pin_i,
  input  wire rising_i,
  output wire edge_o
);

  reg sync_first;
  reg sync_second;
  reg sync_prev;

  always @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      sync_first  <= 1'b0;
      sync_second <= 1'b0;
      sync_prev   <= 1'b0;
    end
    else if (ce_i)
    begin
      sync_first  <= pin_i;
      sync_second <= sync_first;
      sync_prev   <= sync_second;
    end
  end

  // only the second stage and its delayed copy feed the compare
  assign edge_o = ce_i & (rising_i ? (sync_second & ~sync_prev) : (~sync_second & sync_prev));

endmodule // line_edge_detect

// *** rtl/port_half_regs.v ***
`timescale 1ns/100ps

// =====================================================================
// output data and direction storage for one 16-pin half
// =====================================================================
module port_half_regs #(
  parameter WIDTH = 16
) (
  input  wire             clock_i,
  input  wire             reset_n_i,
  input  wire             ce_i,
  input  wire             wr_data_i,
  input  wire             wr_dir_i,
  input  wire [WIDTH-1:0] wdata_i,
  output reg  [WIDTH-1:0] out_data_o,
  output reg  [WIDTH-1:0] direction_o
);

  always @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      out_data_o  <= {WIDTH{1'b0}};
      direction_o <= {WIDTH{1'b0}};
    end
    else if (ce_i)
    begin
      if (wr_data_i)
        out_data_o <= wdata_i;
      if (wr_dir_i)
        direction_o <= wdata_i;
    end
  end

endmodule // port_half_regs

// *** verif/gpio_port_properties.sv ***
`timescale 1ns/100ps

// =====================================================================
// bus, pin and interrupt checks
// =====================================================================
module gpio_port_properties (
  input wire        clock_i,
  input wire        reset_n_i,
  input wire        ce_i,
  input wire        psel_i,
  input wire        penable_i,
  input wire        pwrite_i,
  input wire [31:0] prdata_o,
  input wire        pready_o,
  input wire [31:0] gpio_in_i,
  input wire [31:0] gpio_out_o,
  input wire [31:0] gpio_oe_n_o,
  input wire        proc_irq_enable_i,
  input wire        ext_interrupt_line_zero_o,
  input wire        ext_interrupt_line_one_o,
  input wire        irq_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!reset_n_i);
  wire wr_done = psel_i & penable_i & pready_o & pwrite_i;

  AST_ANSWER: assert property (psel_i && !penable_i && ce_i |=> pready_o)
    else $error("no answer after setup");
  AST_RESET_VAL: assert property ($rose(reset_n_i) |-> gpio_oe_n_o == 32'hFFFF_FFFF && gpio_out_o == 32'h0)
    else $error("pins not idle after reset");
  AST_OUT_HOLD: assert property ($changed(gpio_out_o) |-> $past(wr_done) || !$past(reset_n_i))
    else $error("output data moved without a write");
  AST_DIR_HOLD: assert property ($changed(gpio_oe_n_o) |-> $past(wr_done) || !$past(reset_n_i))
    else $error("drive enable moved without a write");
  AST_UPPER_ZERO: assert property (pready_o && !pwrite_i |-> prdata_o[31:16] == 16'h0000)
    else $error("upper read data not zero");
  AST_GATE: assert property (irq_o |-> proc_irq_enable_i)
    else $error("interrupt passed a closed gate");
  AST_PULSE: assert property (ext_interrupt_line_zero_o |=> !ext_interrupt_line_zero_o)
    else $error("line zero request longer than one cycle");
  AST_SRC0: assert property (ext_interrupt_line_zero_o |-> $past(gpio_in_i[24]) != $past(gpio_in_i[24], 5))
    else $error("line zero request without pin edge");
  AST_SRC1: assert property ($rose(ext_interrupt_line_one_o) |-> $past(gpio_in_i[25]) != $past(gpio_in_i[25], 5))
    else $error("line one request without pin edge");
endmodule // gpio_port_properties

bind gpio_port_with_edge_irqs gpio_port_properties u_gpio_port_properties (.clock_i(clock_i), .reset_n_i(reset_n_i),
  .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .gpio_in_i(gpio_in_i), .gpio_out_o(gpio_out_o), .gpio_oe_n_o(gpio_oe_n_o), .proc_irq_enable_i(proc_irq_enable_i),
  .ext_interrupt_line_zero_o(ext_interrupt_line_zero_o), .ext_interrupt_line_one_o(ext_interrupt_line_one_o),
  .irq_o(irq_o));

// *** verif/pin_model.sv ***
`timescale 1ns/100ps

// =====================================================================
// external devices wired to the port pins
// =====================================================================
module pin_model (
  input  wire logic [31:0] out_i,
  input  wire logic [31:0] oe_n_i,
  input  wire logic [31:0] ext_i,
  output wire logic [31:0] pins_o
);
  // a driven pin shows the port level, a released one the far device level
  assign pins_o = (out_i & ~oe_n_i) | (ext_i & oe_n_i);
endmodule // pin_model

// *** verif/tb_top.sv ***
`timescale 1ns/100ps
`include "gpio_port_consts.vh"

// =====================================================================
// port testbench
// =====================================================================
module tb_top;
  localparam logic [19:0] CTRL = `REG_ADDR(`PORT_CTRL_IDX);
  localparam logic [19:0] STAT = `REG_ADDR(`IRQ_STATUS_IDX);
  localparam logic [19:0] MASK = `REG_ADDR(`IRQ_MASK_IDX);
  logic        clock_i = 0, reset_n_i = 0, psel = 0, penable = 0, pwrite = 0, proc_en = 0, ce = 1;
  logic        pready, pslverr, line0, line1, irq, err;
  logic [19:0] paddr = 0;
  logic [31:0] pwdata = 0, ext = 0, pins, prdata, gout, goe_n, rd;
  int          fail_count = 0, total_checks = 0, pulses [2] = '{0, 0};
  logic [19:0] row_a [6] = '{`REG_ADDR(`PORT_LOW_OUT_IDX), `REG_ADDR(`PORT_HIGH_OUT_IDX),
    `REG_ADDR(`PORT_LOW_DIR_IDX), `REG_ADDR(`PORT_HIGH_DIR_IDX), `REG_ADDR(`PORT_LOW_IN_IDX), `REG_ADDR(`PORT_HIGH_IN_IDX)};
  logic [31:0] row_d [6] = '{32'h0000_A5C3, 32'h0000_3C5A, 32'h0000_00FF, 32'h0000_F000, 32'h0000_FFFF, 32'h0000_FFFF};
  logic [31:0] row_e [6] = '{32'h0000_A5C3, 32'h0000_3C5A, 32'h0000_00FF, 32'h0000_F000, 32'h0000_56C3, 32'h0000_3234};
  logic [5:0]  row_err = 6'h30;

  pin_model u_pin_model (.out_i(gout), .oe_n_i(goe_n), .ext_i(ext), .pins_o(pins));
  gpio_port_with_edge_irqs u_gpio_port_with_edge_irqs (.clock_i(clock_i), .reset_n_i(reset_n_i), .ce_i(ce),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .gpio_in_i(pins), .gpio_out_o(gout), .gpio_oe_n_o(goe_n),
    .proc_irq_enable_i(proc_en), .ext_interrupt_line_zero_o(line0), .ext_interrupt_line_one_o(line1), .irq_o(irq));

  initial forever #25 clock_i = ~clock_i;
  always @(posedge clock_i)
  begin
    pulses[0] <= pulses[0] + int'(line0 === 1'b1);
    pulses[1] <= pulses[1] + int'(line1 === 1'b1);
  end

  // =====================================================================
  // tasks
  // =====================================================================
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // holds the request until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [19:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1;
    // only the watchdog ends a wait that never sees pready
    do @(posedge clock_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    #100000;
    fail_count++;
    conclude();
  end

  // =====================================================================
  // main sequence
  // =====================================================================
  initial
  begin
    int l;
    int r;
    int base;
    repeat (3) @(posedge clock_i);
    reset_n_i <= 1;
    for (int i = 0; i < 6; i++)
    begin
      apb(0, row_a[i], 0);
      chk("reset value", 0, rd);
    end
    ext <= 32'h1234_5678;
    for (int i = 0; i < 6; i++)
    begin
      apb(1, row_a[i], row_d[i]);
      chk("write error", 32'(row_err[i]), 32'(err));
      apb(0, row_a[i], 0);
      chk("readback", row_e[i], rd);
    end
    chk("pin drive", 32'h3C5A_A5C3, gout);
    chk("pin enable", ~32'hF000_00FF, goe_n);
    apb(0, `REG_ADDR(18'h0_C004), 0);
    chk("unmapped error", 1, 32'(err));
    apb(1, CTRL, 32'h0000_0100);
    @(negedge clock_i);
    chk("mode release", ~(32'hF000_00FF & ~`MODE_OWNED_PINS), goe_n);
    apb(1, CTRL, 0);
    @(negedge clock_i);
    chk("mode plain", ~32'hF000_00FF, goe_n);
    apb(1, MASK, 32'h0000_0003);
    proc_en <= 1;
    for (int i = 0; i < 4; i++)
    begin
      l = i / 2;
      r = i % 2;
      apb(1, CTRL, 32'((1 << (2 * l)) | (r << (2 * l + 1))));
      ext[24 + l] <= r[0];
      repeat (8) @(posedge clock_i);
      apb(1, STAT, 32'h0000_0003);
      base = pulses[l];
      ext[24 + l] <= !r[0];
      repeat (8) @(posedge clock_i);
      chk("wrong edge", base, pulses[l]);
      ext[24 + l] <= r[0];
      repeat (8) @(posedge clock_i);
      chk("right edge", base + 1, pulses[l]);
      apb(0, STAT, 0);
      chk("status", 1 << l, rd);
      @(negedge clock_i);
      chk("irq on", 1, 32'(irq));
      apb(1, MASK, 0);
      @(negedge clock_i);
      chk("irq masked", 0, 32'(irq));
      apb(1, MASK, 32'h0000_0003);
      proc_en <= 0;
      @(negedge clock_i);
      chk("irq gated", 0, 32'(irq));
      apb(1, STAT, 1 << l);
      proc_en <= 1;
      apb(0, STAT, 0);
      chk("cleared", 0, rd);
    end
    apb(1, CTRL, 0);
    ext[24] <= !ext[24];
    repeat (8) @(posedge clock_i);
    apb(0, STAT, 0);
    chk("disabled status", 0, rd);
    // clock enable low must hold the synchroniser, the edge shows once it runs again
    apb(1, CTRL, 32'h0000_0003);
    base = pulses[0];
    ce <= 0;
    ext[24] <= 1;
    repeat (2) @(posedge clock_i);
    chk("frozen edge", base, pulses[0]);
    ce <= 1;
    repeat (8) @(posedge clock_i);
    chk("edge after enable", base + 1, pulses[0]);
    // write protect locks the pin-use field and itself until reset
    apb(1, CTRL, 32'h0000_8003);
    apb(1, CTRL, 32'h0000_0103);
    apb(0, CTRL, 0);
    chk("write protect", 32'h0000_8003, rd);
    apb(1, CTRL, 32'h0000_0003);
    apb(0, CTRL, 0);
    chk("protect sticky", 32'h0000_8003, rd);
    chk("mode locked", ~32'hF000_00FF, goe_n);
    // reset in mid-run returns every register and pin to idle
    reset_n_i <= 0;
    repeat (2) @(posedge clock_i);
    reset_n_i <= 1;
    @(negedge clock_i);
    chk("reset drive", 0, gout);
    chk("reset enable", 32'hFFFF_FFFF, goe_n);
    chk("reset irq", 0, 32'(irq));
    apb(0, CTRL, 0);
    chk("reset ctrl", 0, rd);
    apb(0, row_a[0], 0);
    chk("reset out data", 0, rd);
    conclude();
  end
endmodule // tb_top
